// >>> core/bpm_pkg.sv
/*
  Shared constants and types of the bridge power-management block:
  register offsets, field positions, reset values, state codes and
  the packed carriers. Assumes a 32-bit AXI4-Lite register bus.
*/
package bpm_pkg;

  localparam int unsigned BPM_AW          = 8;
  localparam int unsigned BPM_DW          = 32;

  // register byte offsets
  localparam logic [7:0]  BPM_OFS_PM_CTRL   = 8'h00;
  localparam logic [7:0]  BPM_OFS_SLOT_STAT = 8'h04;
  localparam logic [7:0]  BPM_OFS_SLOT_CTRL = 8'h08;
  localparam logic [7:0]  BPM_OFS_IRQ_STAT  = 8'h0C;
  localparam logic [7:0]  BPM_OFS_IRQ_MASK  = 8'h10;

  // field positions
  localparam int unsigned BPM_PMC_PS_LSB    = 0;
  localparam int unsigned BPM_PMC_WEN_BIT   = 8;
  localparam int unsigned BPM_PMC_WSTS_BIT  = 15;
  localparam int unsigned BPM_SS_PRES_BIT   = 0;
  localparam int unsigned BPM_SS_TYPE_LSB   = 1;
  localparam int unsigned BPM_SS_VCC_BIT    = 3;
  localparam int unsigned BPM_SS_PM_LSB     = 4;
  localparam int unsigned BPM_SS_COLD_BIT   = 6;
  localparam int unsigned BPM_SC_VCC_BIT    = 0;
  localparam int unsigned BPM_IRQ_INS_BIT   = 0;
  localparam int unsigned BPM_IRQ_REM_BIT   = 1;
  localparam int unsigned BPM_IRQ_WAKE_BIT  = 2;
  localparam int unsigned BPM_IRQ_N         = 3;

  // reset values
  localparam logic [2:0]  BPM_IRQ_MASK_RST  = 3'h0;
  localparam logic        BPM_WEN_RST       = 1'b0;
  localparam logic        BPM_VCC_RST       = 1'b0;
  localparam logic        BPM_CLK_RUN_RST   = 1'b1;

  // power-state field values written by software
  localparam logic [1:0]  BPM_PS_D0         = 2'h0;
  localparam logic [1:0]  BPM_PS_D3         = 2'h3;

  localparam logic [1:0]  BPM_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  BPM_RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    BPM_PM_UNINIT = 2'b00,
    BPM_PM_ACTIVE = 2'b01,
    BPM_PM_D3HOT  = 2'b11
  } bpm_pm_t;

  typedef enum logic [2:0] {
    BPM_SEL_PMC   = 3'b000,
    BPM_SEL_SSTAT = 3'b001,
    BPM_SEL_SCTRL = 3'b010,
    BPM_SEL_ISTAT = 3'b011,
    BPM_SEL_IMASK = 3'b100,
    BPM_SEL_NONE  = 3'b111
  } bpm_sel_t;

  typedef struct packed {
    logic       present;
    logic [1:0] ctype;
  } bpm_slot_t;

endpackage

// >>> core/bpm_sync.sv
/*
  Two-flop synchroniser for a group of slot pins.
  Assumes inputs are asynchronous to aclk; nothing reads stage one.
  Not reset: the stages flush with the live pins while reset is held,
  so no false pin edge appears after a reset release.
*/
`timescale 1ns/1ps
module bpm_sync
  import bpm_pkg::*;
#(
  parameter int unsigned W = 4
)(
  input  wire logic         aclk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bpm_sync_st_t;

  bpm_sync_st_t st_ff;
  bpm_sync_st_t nxt_st;

  always_comb
  begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge aclk)
  begin
    st_ff <= nxt_st;
  end

  assign q = st_ff.s2;

endmodule // bpm_sync

// >>> core/bpm_irq.sv
/*
  Sticky event status with clear-on-read, a mask of the same layout
  and one level interrupt. Assumes one aclk domain; gate comes from
  the power-state logic of the parent.
*/
`timescale 1ns/1ps
module bpm_irq
  import bpm_pkg::*;
#(
  parameter int unsigned N = BPM_IRQ_N
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [N-1:0] set_evt,
  input  wire logic         rd_clr,
  input  wire logic         mask_wr,
  input  wire logic [N-1:0] mask_wdata,
  input  wire logic         gate,
  output logic      [N-1:0] status,
  output logic      [N-1:0] mask,
  output logic              irq
);

  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
  } bpm_irq_st_t;

  bpm_irq_st_t st_ff;
  bpm_irq_st_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    // event in the clearing cycle survives: set is or-ed after the clear
    if (rd_clr)
    begin
      nxt_st.status = '0;
    end
    nxt_st.status = nxt_st.status | set_evt;
    if (mask_wr)
    begin
      nxt_st.mask = mask_wdata;
    end
    if (!aresetn)
    begin
      nxt_st.status = '0;
      nxt_st.mask   = N'(BPM_IRQ_MASK_RST);
    end
  end

  always_ff @(posedge aclk)
  begin
    st_ff <= nxt_st;
  end

  assign status = st_ff.status;
  assign mask   = st_ff.mask;
  assign irq    = gate & (|(st_ff.status & st_ff.mask));

endmodule // bpm_irq

// >>> core/bpm_core.sv
/*
  Power-management core of the slot bridge function: power state,
  slot supply control, wake-event context, clock-run keep-alive,
  interrupt gating and the AXI4-Lite register slave that stands in
  for configuration access. Assumes one 200 MHz aclk, aresetn as the
  primary bus segment reset and por_n as power-on reset on aclk.
*/
`timescale 1ns/1ps

// How it works
// R01: uninit, wake disabled: supply off, detect valid.
// R02: context is firmware-written or power-on defaults.
// R03: wake enabled: keep wake context and supply.
// R04: arriving from cold keeps applied slot supply.
// R05: host keeps primary bus in B0, working.
// R06: clock runs unless clock-run asks it stop.
// R07: no interrupts signalled while uninitialized.
// R08: config accesses always answered correctly.
// R09: segment reset enters uninit; software leaves it.
module bpm_core
  import bpm_pkg::*;
#(
  parameter logic ISA_IRQ_EN = 1'b1
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              por_n,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [BPM_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [BPM_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic      [1:0]        s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [BPM_AW-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic      [BPM_DW-1:0] s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  input  wire logic [1:0]        card_detect_n,
  input  wire logic [1:0]        card_sense,
  input  wire logic              clkrun_functional,
  input  wire logic              clkrun_stop_req,
  output logic                   slot_vcc_en,
  output logic                   pci_clk_run,
  output logic                   irq,
  output logic                   isa_irq,
  output logic                   wake_req
);

  typedef struct packed {
    bpm_pm_t           pm;
    logic              from_cold;
    logic              wake_en;
    logic              wake_sts;
    logic              vcc_on;
    logic              present_d;
    logic              clk_run;
    logic              aw_ok;
    logic              w_ok;
    logic [BPM_AW-1:0] awaddr;
    logic [BPM_DW-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [BPM_DW-1:0] rdata;
  } bpm_core_st_t;

  bpm_core_st_t st_ff;
  bpm_core_st_t nxt_st;

  logic [3:0]           pins_s;
  bpm_slot_t            slot;
  logic                 clkrun_fn_s;
  logic [BPM_IRQ_N-1:0] evt;
  logic [BPM_IRQ_N-1:0] irq_status;
  logic [BPM_IRQ_N-1:0] irq_mask;
  logic                 rd_clr;
  logic                 mask_wr;
  logic                 irq_gate;
  logic                 card_ins;
  logic                 card_rem;
  logic [BPM_DW-1:0]    wd;
  bpm_sel_t             sel_w;
  bpm_sel_t             sel_r;

  function automatic bpm_sel_t bpm_dec(input logic [BPM_AW-1:0] a);
    if (a == BPM_OFS_PM_CTRL)
      bpm_dec = BPM_SEL_PMC;
    else if (a == BPM_OFS_SLOT_STAT)
      bpm_dec = BPM_SEL_SSTAT;
    else if (a == BPM_OFS_SLOT_CTRL)
      bpm_dec = BPM_SEL_SCTRL;
    else if (a == BPM_OFS_IRQ_STAT)
      bpm_dec = BPM_SEL_ISTAT;
    else if (a == BPM_OFS_IRQ_MASK)
      bpm_dec = BPM_SEL_IMASK;
    else
      bpm_dec = BPM_SEL_NONE;
  endfunction

  function automatic logic [BPM_DW-1:0] bpm_strb_mask(input logic [3:0] s);
    bpm_strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // slot pins and the clock-run strap come from outside aclk
  bpm_sync #(
    .W (5)
  ) u_pin_sync (
    .aclk    (aclk),
    .d       ({clkrun_functional, card_sense, card_detect_n}),
    .q       ({clkrun_fn_s, pins_s})
  );

  // detect stays live in every state, so status is always valid
  assign slot.present = ~pins_s[0] & ~pins_s[1]; // [R01]
  assign slot.ctype   = pins_s[3:2];             // [R01]

  assign card_ins = slot.present & ~st_ff.present_d;
  assign card_rem = ~slot.present & st_ff.present_d;

  always_comb
  begin
    evt                   = '0;
    evt[BPM_IRQ_INS_BIT]  = card_ins;
    evt[BPM_IRQ_REM_BIT]  = card_rem;
    evt[BPM_IRQ_WAKE_BIT] = st_ff.wake_en & (card_ins | card_rem);
  end

  // functional interrupts only once software has brought it to D0
  assign irq_gate = (st_ff.pm == BPM_PM_ACTIVE); // [R07]

  bpm_irq #(
    .N (BPM_IRQ_N)
  ) u_irq (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .set_evt    (evt),
    .rd_clr     (rd_clr),
    .mask_wr    (mask_wr),
    .mask_wdata (st_ff.wdata[BPM_IRQ_N-1:0]),
    .gate       (irq_gate),
    .status     (irq_status),
    .mask       (irq_mask),
    .irq        (irq)
  );

  assign isa_irq = ISA_IRQ_EN & irq; // [R07]

  assign sel_w = bpm_dec(st_ff.awaddr);
  assign sel_r = bpm_dec(s_axi_araddr);
  assign wd    = st_ff.wdata & bpm_strb_mask(st_ff.wstrb);

  assign s_axi_awready = ~st_ff.aw_ok;
  assign s_axi_wready  = ~st_ff.w_ok;
  assign s_axi_arready = ~st_ff.rvalid;
  assign rd_clr        = s_axi_arvalid & ~st_ff.rvalid & (sel_r == BPM_SEL_ISTAT);

  always_comb
  begin
    nxt_st  = st_ff;
    mask_wr = 1'b0;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && !st_ff.aw_ok)
    begin
      nxt_st.aw_ok  = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.w_ok)
    begin
      nxt_st.w_ok  = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready)
    begin
      nxt_st.bvalid = 1'b0;
    end

    // every state answers config access; no gating on pm
    if (st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid) // [R08]
    begin
      nxt_st.aw_ok  = 1'b0;
      nxt_st.w_ok   = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = (sel_w == BPM_SEL_NONE) ? BPM_RESP_SLVERR : BPM_RESP_OKAY;
      if (sel_w == BPM_SEL_PMC)
      begin
        if (st_ff.wstrb[1])
        begin
          nxt_st.wake_en = wd[BPM_PMC_WEN_BIT];
          if (wd[BPM_PMC_WSTS_BIT])
          begin
            nxt_st.wake_sts = 1'b0;
          end
        end
        if (st_ff.wstrb[0])
        begin
          case (st_ff.pm)
            BPM_PM_UNINIT:
            begin
              // only D0 or D3 takes it out of the uninitialized state
              if (wd[1:0] == BPM_PS_D0)
                nxt_st.pm = BPM_PM_ACTIVE; // [R09]
              else if (wd[1:0] == BPM_PS_D3)
                nxt_st.pm = BPM_PM_D3HOT;  // [R09]
            end
            BPM_PM_ACTIVE:
            begin
              if (wd[1:0] == BPM_PS_D3)
                nxt_st.pm = BPM_PM_D3HOT;
            end
            BPM_PM_D3HOT:
            begin
              if (wd[1:0] == BPM_PS_D0)
                nxt_st.pm = BPM_PM_UNINIT;
            end
            default:
            begin
              nxt_st.pm = BPM_PM_UNINIT;
            end
          endcase
        end
      end
      else if (sel_w == BPM_SEL_SCTRL)
      begin
        // supply is software's only once the function is active
        if (st_ff.wstrb[0] && st_ff.pm == BPM_PM_ACTIVE)
        begin
          nxt_st.vcc_on = wd[BPM_SC_VCC_BIT] & slot.present;
        end
      end
      else if (sel_w == BPM_SEL_IMASK)
      begin
        mask_wr = st_ff.wstrb[0];
      end
    end

    // read channel: one cycle from address to data
    if (st_ff.rvalid && s_axi_rready)
    begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_ff.rvalid) // [R08]
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = BPM_RESP_OKAY;
      nxt_st.rdata  = '0;
      if (sel_r == BPM_SEL_PMC)
      begin
        nxt_st.rdata[BPM_PMC_PS_LSB +: 2] = st_ff.pm;
        nxt_st.rdata[BPM_PMC_WEN_BIT]     = st_ff.wake_en;
        nxt_st.rdata[BPM_PMC_WSTS_BIT]    = st_ff.wake_sts;
      end
      else if (sel_r == BPM_SEL_SSTAT)
      begin
        nxt_st.rdata[BPM_SS_PRES_BIT]     = slot.present; // [R01]
        nxt_st.rdata[BPM_SS_TYPE_LSB +: 2] = slot.ctype;  // [R01]
        nxt_st.rdata[BPM_SS_VCC_BIT]      = st_ff.vcc_on;
        nxt_st.rdata[BPM_SS_PM_LSB +: 2]  = st_ff.pm;
        nxt_st.rdata[BPM_SS_COLD_BIT]     = st_ff.from_cold;
      end
      else if (sel_r == BPM_SEL_SCTRL)
      begin
        nxt_st.rdata[BPM_SC_VCC_BIT] = st_ff.vcc_on;
      end
      else if (sel_r == BPM_SEL_ISTAT)
      begin
        nxt_st.rdata[BPM_IRQ_N-1:0] = irq_status;
      end
      else if (sel_r == BPM_SEL_IMASK)
      begin
        nxt_st.rdata[BPM_IRQ_N-1:0] = irq_mask;
      end
      else
      begin
        nxt_st.rresp = BPM_RESP_SLVERR;
      end
    end

    // slot supervision
    nxt_st.present_d = slot.present;
    if (evt[BPM_IRQ_WAKE_BIT])
    begin
      nxt_st.wake_sts = 1'b1; // [R03]
    end
    if (card_rem)
    begin
      nxt_st.vcc_on = 1'b0; // [R03]
    end
    if (st_ff.pm == BPM_PM_UNINIT && !st_ff.wake_en && !st_ff.from_cold)
    begin
      nxt_st.vcc_on = 1'b0; // [R01]
    end
    if (st_ff.pm != BPM_PM_UNINIT)
    begin
      nxt_st.from_cold = 1'b0;
    end

    // clock only stops when a working clock-run mechanism asks
    nxt_st.clk_run = ~(clkrun_fn_s & clkrun_stop_req); // [R06]

    if (!por_n)
    begin
      // power removed: all core state back to power-on defaults; irq status and mask reset only on aresetn
      nxt_st           = '0; // [R02]
      nxt_st.pm        = BPM_PM_UNINIT; // [R09]
      nxt_st.wake_en   = BPM_WEN_RST;
      nxt_st.vcc_on    = BPM_VCC_RST;
      nxt_st.clk_run   = BPM_CLK_RUN_RST;
    end
    else if (!aresetn)
    begin
      // segment reset spares wake context and, from cold, the supply
      nxt_st.pm        = BPM_PM_UNINIT; // [R09]
      nxt_st.from_cold = (st_ff.pm == BPM_PM_D3HOT) | st_ff.from_cold; // [R04]
      nxt_st.vcc_on    = st_ff.vcc_on & ~card_rem
                         & (st_ff.wake_en | nxt_st.from_cold); // [R03] [R04]
      nxt_st.clk_run   = BPM_CLK_RUN_RST;
      nxt_st.aw_ok     = 1'b0;
      nxt_st.w_ok      = 1'b0;
      nxt_st.bvalid    = 1'b0;
      nxt_st.rvalid    = 1'b0;
      nxt_st.bresp     = BPM_RESP_OKAY;
      nxt_st.rresp     = BPM_RESP_OKAY;
      nxt_st.rdata     = '0;
      // wake_en is held at its previous value and wake_sts is not touched here
      nxt_st.wake_en   = st_ff.wake_en; // [R03]
    end
  end

  always_ff @(posedge aclk)
  begin
    st_ff <= nxt_st;
  end

  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp  = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata  = st_ff.rdata;
  assign s_axi_rresp  = st_ff.rresp;
  assign slot_vcc_en  = st_ff.vcc_on;
  assign pci_clk_run  = st_ff.clk_run;
  assign wake_req     = st_ff.wake_en & st_ff.wake_sts;

endmodule // bpm_core

// >>> verification/bpm_core_props.sv
/*
  Port-level assertions of the power-management core.
  Assumes one aclk domain, both resets synchronous and active low.
*/
`timescale 1ns/1ps
module bpm_core_props
  import bpm_pkg::*;
#(
  parameter logic ISA_IRQ_EN = 1'b1
)(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        por_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [1:0]  card_detect_n,
  input wire logic        clkrun_functional,
  input wire logic        clkrun_stop_req,
  input wire logic        slot_vcc_en,
  input wire logic        pci_clk_run,
  input wire logic        irq,
  input wire logic        isa_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !por_n);

  // no write since reset means software never left uninit
  logic wr_seen_ff;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !por_n)
      wr_seen_ff <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
      wr_seen_ff <= 1'b1;
  end

  isa_follows_a: assert property (isa_irq == (irq && ISA_IRQ_EN))
    else $error("isa interrupt differs from interrupt");
  uninit_quiet_a: assert property (!wr_seen_ff |-> !irq && !isa_irq)
    else $error("interrupt raised while uninitialized");
  reset_quiet_a: assert property (disable iff (!por_n) !aresetn |=> !irq)
    else $error("interrupt after segment reset");
  reset_no_vcc_a: assert property (disable iff (!por_n)
    !aresetn |=> !$rose(slot_vcc_en))
    else $error("segment reset switched supply on");
  clk_nofunc_a: assert property (!clkrun_functional [*4] |-> pci_clk_run)
    else $error("clock stopped without working clock-run");
  clk_nostop_a: assert property (!clkrun_stop_req [*3] |-> pci_clk_run)
    else $error("clock stopped without request");
  removal_off_a: assert property ((card_detect_n != 2'h0) [*6] |-> !slot_vcc_en)
    else $error("supply on with empty slot");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  resp_drop_a: assert property ((s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) and
    (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid))
    else $error("response repeated");
  rresp_code_a: assert property (s_axi_rvalid |->
    s_axi_rresp == BPM_RESP_OKAY || s_axi_rresp == BPM_RESP_SLVERR)
    else $error("bad read response code");
endmodule // bpm_core_props

bind bpm_core bpm_core_props #(.ISA_IRQ_EN(ISA_IRQ_EN)) bpm_core_props_i (
  .aclk(aclk), .aresetn(aresetn), .por_n(por_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rresp(s_axi_rresp), .card_detect_n(card_detect_n),
  .clkrun_functional(clkrun_functional), .clkrun_stop_req(clkrun_stop_req),
  .slot_vcc_en(slot_vcc_en), .pci_clk_run(pci_clk_run), .irq(irq), .isa_irq(isa_irq)
);

// >>> verification/bpm_slot_model.sv
/*
  Slot and host-side strap model facing the core.
  Assumes the bench drives its inputs on aclk edges.
*/
`timescale 1ns/1ps
module bpm_slot_model (
  input  wire logic       card_in,
  input  wire logic [1:0] ctype,
  input  wire logic       cr_ok,
  input  wire logic       cr_stop,
  output logic      [1:0] card_detect_n,
  output logic      [1:0] card_sense,
  output logic            clkrun_functional,
  output logic            clkrun_stop_req
);
  // sense pins have pull-ups, so an empty slot reads all ones
  assign card_detect_n = card_in ? 2'h0 : 2'h3;
  assign card_sense = card_in ? ctype : 2'h3;
  // host keeps the primary bus in B0, register access always possible
  assign clkrun_functional = cr_ok;
  assign clkrun_stop_req = cr_stop;
endmodule // bpm_slot_model

// >>> verification/tb.sv
/*
  Self-checking bench of the power-management core.
  Assumes bpm_pkg, the slot model and the bound checker.
*/
`timescale 1ns/1ps
module tb;
  import bpm_pkg::*;
  logic        aclk, aresetn, por_n, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic        cf, csr, vcc, crun, irq, isa, wake, card, cok, stop;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0]  bres, rres, cdn, cs, ct;
  logic [3:0]  ws;
  int          err_total, n_tests, cyc;

  bpm_core bpm_core_i (
    .aclk(aclk), .aresetn(aresetn), .por_n(por_n),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bres),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rres),
    .card_detect_n(cdn), .card_sense(cs), .clkrun_functional(cf),
    .clkrun_stop_req(csr), .slot_vcc_en(vcc), .pci_clk_run(crun), .irq(irq),
    .isa_irq(isa), .wake_req(wake)
  );
  bpm_slot_model bpm_slot_model_i (
    .card_in(card), .ctype(ct), .cr_ok(cok), .cr_stop(stop), .card_detect_n(cdn),
    .card_sense(cs), .clkrun_functional(cf), .clkrun_stop_req(csr)
  );

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  function automatic logic [31:0] ss(logic p, logic [1:0] t, logic v, logic [1:0] s, logic c);
    return {25'h0, c, s, v, t, p};
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    chk(32'(bres), 32'(er));
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
    chk(rdat, exp);
    chk(32'(rres), 32'(er));
  endtask

  // segment reset, or power-on reset when p is set
  task automatic rst(input logic p);
    @(posedge aclk);
    aresetn <= 1'b0;
    por_n <= !p;
    wt(3);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    wt(1);
  endtask

  initial
  begin
    cyc = 0;
    forever
    begin
      @(posedge aclk);
      cyc++;
      if (cyc == 20000)
      begin
        err_total++;
        end_sim();
      end
    end
  end

  initial
  begin
    void'($urandom(32'h8ACE));
    {aresetn, por_n, awv, wv, br, arv, rr, card, cok, stop} = '0;
    {awa, ara, wd, ct} = '0;
    ws = 4'hF;
    err_total = 0;
    n_tests = 0;
    wt(6);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    card <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      ct <= 2'(i);
      wt(4);
      rd_chk(BPM_OFS_SLOT_STAT, ss(1'b1, 2'(i), 1'b0, 2'h0, 1'b0), BPM_RESP_OKAY);
    end
    rd_chk(BPM_OFS_PM_CTRL, 32'h0, BPM_RESP_OKAY);
    wr_reg(BPM_OFS_IRQ_MASK, 32'h7, BPM_RESP_OKAY);
    wr_reg(BPM_OFS_SLOT_CTRL, 32'h1, BPM_RESP_OKAY);
    chk(32'(vcc), 32'h0);
    chk(32'({irq, isa}), 32'h0);
    rd_chk(BPM_OFS_IRQ_STAT, 32'h1, BPM_RESP_OKAY);
    rd_chk(BPM_OFS_IRQ_STAT, 32'h0, BPM_RESP_OKAY);
    for (int i = 0; i < 3; i++)
    begin
      rd_chk(8'h14 + 8'($urandom % 59) * 8'h4, 32'h0, BPM_RESP_SLVERR);
      wr_reg(8'h14 + 8'($urandom % 59) * 8'h4, $urandom, BPM_RESP_SLVERR);
    end
    // active: interrupts work, masking silences them
    wr_reg(BPM_OFS_PM_CTRL, 32'h0, BPM_RESP_OKAY);
    rd_chk(BPM_OFS_PM_CTRL, 32'h1, BPM_RESP_OKAY);
    card <= 1'b0;
    wt(5);
    chk(32'({irq, isa}), 32'h3);
    wr_reg(BPM_OFS_IRQ_MASK, 32'h0, BPM_RESP_OKAY);
    chk(32'(irq), 32'h0);
    rd_chk(BPM_OFS_IRQ_STAT, 32'h2, BPM_RESP_OKAY);
    wr_reg(BPM_OFS_IRQ_MASK, 32'h7, BPM_RESP_OKAY);
    card <= 1'b1;
    wt(5);
    rd_chk(BPM_OFS_IRQ_STAT, 32'h1, BPM_RESP_OKAY);
    // wake enabled: supply and wake context survive the segment reset
    wr_reg(BPM_OFS_PM_CTRL, 32'h100, BPM_RESP_OKAY);
    wr_reg(BPM_OFS_SLOT_CTRL, 32'h1, BPM_RESP_OKAY);
    chk(32'(vcc), 32'h1);
    rst(1'b0);
    chk(32'(vcc), 32'h1);
    rd_chk(BPM_OFS_PM_CTRL, 32'h100, BPM_RESP_OKAY);
    card <= 1'b0;
    wt(6);
    chk(32'({vcc, wake, irq}), 32'h2);
    rd_chk(BPM_OFS_PM_CTRL, 32'h8100, BPM_RESP_OKAY);
    wr_reg(BPM_OFS_PM_CTRL, 32'h8001, BPM_RESP_OKAY);
    rd_chk(BPM_OFS_PM_CTRL, 32'h0, BPM_RESP_OKAY);
    // leaving D3 through reset keeps the applied supply
    card <= 1'b1;
    wt(5);
    wr_reg(BPM_OFS_PM_CTRL, 32'h0, BPM_RESP_OKAY);
    wr_reg(BPM_OFS_SLOT_CTRL, 32'h1, BPM_RESP_OKAY);
    wr_reg(BPM_OFS_PM_CTRL, 32'h3, BPM_RESP_OKAY);
    rd_chk(BPM_OFS_PM_CTRL, 32'h3, BPM_RESP_OKAY);
    rst(1'b0);
    chk(32'(vcc), 32'h1);
    rd_chk(BPM_OFS_SLOT_STAT, ss(1'b1, ct, 1'b1, 2'h0, 1'b1), BPM_RESP_OKAY);
    // uninit straight to D3, byte-1 strobe only, then software back to uninit
    wr_reg(BPM_OFS_PM_CTRL, 32'h3, BPM_RESP_OKAY);
    ws <= 4'h2;
    wr_reg(BPM_OFS_PM_CTRL, 32'h100, BPM_RESP_OKAY);
    ws <= 4'hF;
    rd_chk(BPM_OFS_PM_CTRL, 32'h103, BPM_RESP_OKAY);
    wr_reg(BPM_OFS_PM_CTRL, 32'h0, BPM_RESP_OKAY);
    rd_chk(BPM_OFS_SLOT_STAT, ss(1'b1, ct, 1'b0, 2'h0, 1'b0), BPM_RESP_OKAY);
    for (int i = 0; i < 10; i++)
    begin
      cok <= 1'($urandom);
      stop <= 1'($urandom);
      wt(6);
      chk(32'(crun), 32'(!(cok && stop)));
    end
    stop <= 1'b0;
    wr_reg(BPM_OFS_PM_CTRL, 32'h101, BPM_RESP_OKAY);
    rd_chk(BPM_OFS_PM_CTRL, 32'h100, BPM_RESP_OKAY);
    rst(1'b1);
    chk(32'(vcc), 32'h0);
    rd_chk(BPM_OFS_PM_CTRL, 32'h0, BPM_RESP_OKAY);
    end_sim();
  end
endmodule // tb
